/* File: bench/msdu_host_model.sv */
/*
   Behavioural host that offers sub-message bytes to the checker, one per take.
   Assumes the bench calls send and drives the clock enable at falling edges.
*/
module msdu_host_model
(
   // Clock and flow control
   input  wire logic       sys_clk,
   input  wire logic       clk_en,
   input  wire logic       in_ready,
   // Byte stream
   output logic            in_valid,
   output logic [7:0]      in_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic slow;
   int   stuck;

   initial
   begin
      in_valid = 1'b0;
      in_data  = 8'h00;
      slow     = 1'b0;
      stuck    = 0;
   end

   // An idle data line shows the inverse of the last byte, so a stale copy never matches.
   task automatic send(input logic [7:0] q[$]);
      int n;
      foreach (q[k])
      begin
         @(negedge sys_clk);
         if (slow && (k % 3 == 1))
         begin
            in_valid <= 1'b0;
            in_data  <= ~in_data;
            @(negedge sys_clk);
         end
         in_valid <= 1'b1;
         in_data  <= q[k];
         n = 0;
         do
         begin
            @(posedge sys_clk);
            n++;
         end
         while (!(in_valid && in_ready && clk_en) && n < 100);
         if (n >= 100)
            stuck++;
      end
      @(negedge sys_clk);
      in_valid <= 1'b0;
      in_data  <= ~in_data;
   endtask
endmodule

/* File: bench/msdu_tx_param_checker_bench.sv */
/*
   Self-checking bench of the sub-message checker, with a reference model.
   Assumes the design files and the host model are compiled before it.
*/
module msdu_tx_param_checker_bench
   import msdu_tx_param_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------
   // Signals and model state
   // ---------------------------------
   logic         sys_clk, resetn, clk_en, in_valid, in_ready, jitter;
   logic         param_valid, param_error, to_ds, from_ds, ordering_or_htctl_flag;
   logic [7:0]   in_data, msdu_index, idx;
   logic [1:0]   frame_type;
   logic [3:0]   subtype;
   logic [15:0]  msdu_len, lfsr;
   logic [47:0]  src_addr, dst_addr, bssid, rcv_addr, tx_addr;
   err_t         err_flags;
   logic [7:0]   body [41];
   logic [272:0] exp_f;
   int           fails, tests_run;
   wire  logic [272:0] got_f = {msdu_index, frame_type, subtype, to_ds, from_ds,
      ordering_or_htctl_flag, src_addr, dst_addr, bssid, rcv_addr, tx_addr, msdu_len};

   msdu_tx_param_checker dut_u (.sys_clk, .resetn, .clk_en, .in_valid, .in_data, .in_ready,
      .param_valid, .param_error, .err_flags, .msdu_index, .frame_type, .subtype, .to_ds,
      .from_ds, .ordering_or_htctl_flag, .src_addr, .dst_addr, .bssid, .rcv_addr, .tx_addr,
      .msdu_len);
   msdu_host_model partner_u (.sys_clk, .clk_en, .in_ready, .in_valid, .in_data);

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   // Stretching pulses with a gappy enable is where hold bugs hide.
   always @(negedge sys_clk)
      clk_en <= jitter ? (rnd() % 3 != 0) : 1'b1;

   function automatic logic [47:0] addr(input int o);
      return {body[o], body[o+1], body[o+2], body[o+3], body[o+4], body[o+5]};
   endfunction

   // ---------------------------------
   // Checks and closing
   // ---------------------------------
   task automatic check(input string what, input logic [272:0] exp, input logic [272:0] got);
      tests_run++;
      if (exp !== got)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // A legal body with random addresses; the index steps and wraps as a sender must.
   task automatic fill(input logic [7:0] ft, input logic [7:0] st);
      logic [15:0] len;
      len = rnd() % 16'h0fe2;
      for (int i = 9; i < 39; i++)
         body[i] = 8'(rnd());
      body[0] = idx;
      idx++;
      {body[1], body[2], body[5], body[6], body[7], body[8]} = {ft, st, 32'h0};
      body[3] = 8'(rnd() % 2);
      body[4] = 8'(rnd() % 2);
      body[9][0] = 1'b0;
      body[21][1:0] = 2'b10;
      body[33][0] = 1'b0;
      {body[39], body[40]} = len;
   endtask

   task automatic run(input string what, input logic [7:0] typ, input logic [7:0] sid,
                      input logic [15:0] blen);
      logic [7:0]  q[$];
      err_t        e;
      logic [47:0] sa, ta, bs;
      logic        both;
      int          n;
      q = {typ, sid, blen[15:8], blen[7:0]};
      e = '0;
      if (typ != 8'h00 || sid != 8'h00 || blen != 16'h0029)
      begin
         e.hdr = 1'b1;
         for (int i = 0; i < blen; i++)
            q.push_back(8'(rnd()));
      end
      else
      begin
         foreach (body[i])
            q.push_back(body[i]);
         sa = addr(9);
         bs = addr(21);
         ta = addr(33);
         both = body[3] == 8'h01 && body[4] == 8'h01;
         e.ftype = body[1] != 8'h00 && body[1] != 8'h02;
         e.subtype = (body[1] == 8'h00 && body[2] > 8'h0f) ||
                     (body[1] == 8'h02 && body[2] != 8'h00);
         e.ds = body[3] > 8'h01 || body[4] > 8'h01;
         {e.pwr, e.more, e.prot, e.order} = {|body[5], |body[6], |body[7], |body[8]};
         e.sa = sa[40];
         e.ta = both && ta[40];
         e.bssid = bs[40] || !bs[41] || &bs;
         e.len = {body[39], body[40]} > 16'h0fe1;
         if (e == '0)
            exp_f = {body[0], body[1][1:0], body[2][3:0], body[3][0], body[4][0], 1'b0, sa,
                     addr(15), bs, both ? addr(27) : 48'h0, both ? ta : 48'h0, body[39], body[40]};
      end
      partner_u.send(q);
      if (partner_u.stuck != 0)
      begin
         fails++;
         $display("[FAIL] %s byte take expected within 100 cycles seen none", what);
         summarize();
      end
      // The last byte was taken one edge ago, so the result cycle stalls input now.
      check({what, " ready in result cycle"}, 0, in_ready);
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (!(param_valid || param_error) && n < 200);
      if (n >= 200)
      begin
         fails++;
         $display("[FAIL] %s result expected pulse seen none", what);
         summarize();
      end
      if (!jitter && !partner_u.slow)
         check({what, " latency"}, 1, n);
      check({what, " result"}, {e == '0, e != '0}, {param_valid, param_error});
      check({what, " flags"}, e, err_flags);
      check({what, " fields"}, exp_f, got_f);
      $display("Test %s done", what);
   endtask

   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial
   begin
      {resetn, clk_en, jitter, lfsr, idx, exp_f, fails, tests_run} = '0;
      lfsr = 16'h891c;
      idx = 8'hfe;
      repeat (2) @(negedge sys_clk);
      resetn <= 1'b1;
      for (int s = 0; s < 16; s++)
      begin
         fill(8'h00, 8'(s));
         run("management subtype", 8'h00, 8'h00, 16'h0029);
      end
      for (int k = 0; k < 20; k++)
      begin
         fill((k == 2 || k == 19) ? 8'h02 : 8'h00, 8'h00);
         case (k)
            0: body[1] = 8'h01;
            1: body[1] = 8'h03;
            2: body[2] = 8'h01;
            3: body[2] = 8'h10;
            4: body[3] = 8'h02;
            5: body[5] = 8'h01;
            6: body[6] = 8'h01;
            7: body[7] = 8'h01;
            8: body[8] = 8'h01;
            9: body[9][0] = 1'b1;
            10: {body[3], body[4], body[33][0]} = {16'h0101, 1'b1};
            11: body[21][0] = 1'b1;
            12: body[21][1] = 1'b0;
            13: for (int i = 21; i < 27; i++) body[i] = 8'hff;
            14: {body[39], body[40]} = 16'h0fe2;
            15: {body[39], body[40]} = 16'h0fe1;
            16: {body[39], body[40]} = 16'h0000;
            17: {body[3], body[4], body[33][0]} = {16'h0001, 1'b1};
            18: {body[3], body[4]} = 16'h0101;
            default: ;
         endcase
         run("field case", 8'h00, 8'h00, 16'h0029);
      end
      run("phy type", 8'h01, 8'h00, 16'h0004);
      run("set id", 8'h00, 8'h01, 16'h0029);
      run("short body", 8'h00, 8'h00, 16'h0028);
      run("empty body", 8'h00, 8'h00, 16'h0000);
      jitter = 1'b1;
      partner_u.slow = 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         fill(8'(2 * (k % 2)), 8'h00);
         run("stalled", 8'h00, 8'h00, 16'h0029);
      end
      jitter = 1'b0;
      partner_u.slow = 1'b0;
      @(negedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(negedge sys_clk);
      check("reset state", 15'h0001, {param_valid, param_error, err_flags, in_ready});
      check("reset fields", 0, got_f);
      resetn <= 1'b1;
      exp_f = '0;
      fill(8'h02, 8'h00);
      run("after reset", 8'h00, 8'h00, 16'h0029);
      check("host stalls", 0, partner_u.stuck);
      summarize();
   end
endmodule

/* File: logic/mac_addr_check.sv */
/*
   Individual/group and universal/local checks on three 48-bit addresses.
   Purely combinational; the caller registers whatever it derives from it.
*/
`include "msdu_tx_param_defs.svh"

module mac_addr_check
   import msdu_tx_param_pkg::*;
(
   // Addresses, first octet in the top byte
   input  wire logic [47:0] src_addr,
   input  wire logic [47:0] tx_addr,
   input  wire logic [47:0] bssid,
   input  wire logic        use_tx_addr,
   // Verdicts
   output logic             src_ok,
   output logic             tx_ok,
   output logic             bssid_ok
);

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   always_comb
   begin
      src_ok   = !src_addr[`ADDR_IG_BIT];
      tx_ok    = !use_tx_addr || !tx_addr[`ADDR_IG_BIT];
      // The all-ones wildcard fails here because its group bit is set.
      bssid_ok = !bssid[`ADDR_IG_BIT] && bssid[`ADDR_UL_BIT];
   end

endmodule

/* File: logic/msdu_tx_param_checker.sv */
/*
   Parser and checker of the MSDU transmit-parameters sub-message of a
   transmit configuration request, fed one byte per accepted cycle.
   Assumes bytes arrive in order, multi-byte fields most significant first,
   and that the first byte after reset or after a result is a header byte.
*/
// Functional notes
// - Type byte 0 selects MSDU parameters, 1 PHY; type and set id must be 0.
// - Body length counts bytes after type, set id and length field.
// - MSDU parameter body length must be exactly 41 bytes.
// - Frame type accepted only as management 0 or data 2.
// - Management takes subtype 0 to 15; data takes subtype 0 only.
// - DS flags are 0 or 1; RA and TA used only when both are 1.
// - Power management flag must be 0, active mode only.
// - Protected-frame flag accepted only as 0, no encryption.
// - For non-QoS data the order flag picks strict or relaxed ordering; here the flag must be 0, so relaxed only.
// - Order/HT control flag accepted only as 0.
// - Source address must have its group bit at 0.
// - Used transmitter address must have its group bit at 0.
// - BSSID group bit 0, local bit 1; wildcard unsupported.
// - Destination address is carried as a 48-bit field.
// - MSDU length accepted from 0 through 4065.
`include "msdu_tx_param_defs.svh"

module msdu_tx_param_checker
   import msdu_tx_param_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   // Byte stream of sub-messages
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_data,
   output logic             in_ready,
   // Result
   output logic             param_valid,
   output logic             param_error,
   output err_t             err_flags,
   // Accepted parameters
   output logic [7:0]       msdu_index,
   output logic [1:0]       frame_type,
   output logic [3:0]       subtype,
   output logic             to_ds,
   output logic             from_ds,
   output logic             ordering_or_htctl_flag,
   output logic [47:0]      src_addr,
   output logic [47:0]      dst_addr,
   output logic [47:0]      bssid,
   output logic [47:0]      rcv_addr,
   output logic [47:0]      tx_addr,
   output logic [15:0]      msdu_len
);

   // ----------------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------------
   function automatic logic [47:0] get_addr(input body_t b, input int off);
      logic [47:0] a;
      a = '0;
      for (int i = 0; i < 6; i++)
      begin
         a[47 - 8*i -: 8] = b[off + i];
      end
      return a;
   endfunction

   function automatic logic flag_ok(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   parse_state_t st;
   parse_state_t next_st;
   logic         src_ok;
   logic         tx_ok;
   logic         bssid_ok;
   logic         use_ta;
   logic [15:0]  hdr_len;
   logic         hdr_bad_now;
   err_t         chk;

   assign use_ta = st.body[`OFF_TODS] == 8'h01 && st.body[`OFF_FROMDS] == 8'h01;

   mac_addr_check u_addr_check (
      .src_addr    (get_addr(st.body, `OFF_SA)),
      .tx_addr     (get_addr(st.body, `OFF_TA)),
      .bssid       (get_addr(st.body, `OFF_BSSID)),
      .use_tx_addr (use_ta),
      .src_ok      (src_ok),
      .tx_ok       (tx_ok),
      .bssid_ok    (bssid_ok)
   );

   // ----------------------------------------------------------------------
   // Checks on a complete body
   // ----------------------------------------------------------------------
   always_comb
   begin
      chk         = '0;
      chk.hdr     = st.hdr_bad;
      // A body behind a bad header was never stored, so only the header flag counts.
      if (!st.hdr_bad)
      begin
         chk.ftype   = st.body[`OFF_FTYPE] != `FTYPE_MGMT &&
                       st.body[`OFF_FTYPE] != `FTYPE_DATA;
         chk.subtype = (st.body[`OFF_FTYPE] == `FTYPE_MGMT &&
                        st.body[`OFF_SUBTYPE] > `SUBTYPE_MAX) ||
                       (st.body[`OFF_FTYPE] == `FTYPE_DATA &&
                        st.body[`OFF_SUBTYPE] != `SUBTYPE_DATA);
         chk.ds      = st.body[`OFF_TODS] > `FLAG_MAX ||
                       st.body[`OFF_FROMDS] > `FLAG_MAX;
         chk.pwr     = !flag_ok(st.body[`OFF_PWR]);
         chk.more    = !flag_ok(st.body[`OFF_MORE]);
         chk.prot    = !flag_ok(st.body[`OFF_PROT]);
         // Ordering service selection is therefore fixed to relaxed.
         chk.order   = !flag_ok(st.body[`OFF_ORDER]);
         chk.sa      = !src_ok;
         chk.ta      = !tx_ok;
         chk.bssid   = !bssid_ok;
         chk.len     = {st.body[`OFF_LEN], st.body[`OFF_LEN + 1]} > `MSDU_LEN_MAX;
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_st     = st;
      hdr_len     = {st.body_len[15:8], in_data};
      hdr_bad_now = st.hdr_bad || hdr_len != `MSDU_BODY_LEN;
      if (clk_en)
      begin
         next_st.param_valid = 1'b0;
         next_st.param_error = 1'b0;
         case (st.phase)
            S_HDR:
               if (in_valid)
               begin
                  next_st.cnt = 16'(st.cnt + 16'h0001);
                  case (st.cnt[1:0])
                     2'h0: next_st.hdr_bad = in_data != `SUBMSG_TYPE_MSDU;
                     2'h1: next_st.hdr_bad = st.hdr_bad || in_data != `PSET_ID_MSDU;
                     2'h2: next_st.body_len[15:8] = in_data;
                     default:
                     begin
                        // Length excludes the four header bytes, so it counts body bytes.
                        next_st.body_len = hdr_len;
                        next_st.hdr_bad  = hdr_bad_now;
                        next_st.cnt      = '0;
                        if (!hdr_bad_now)
                           next_st.phase = S_BODY;
                        else if (hdr_len == 16'h0000)
                           next_st.phase = S_DONE;
                        else
                           next_st.phase = S_SKIP;
                     end
                  endcase
               end
            S_BODY:
               if (in_valid)
               begin
                  next_st.body[st.cnt[5:0]] = in_data;
                  next_st.cnt = 16'(st.cnt + 16'h0001);
                  if (st.cnt[5:0] == `BODY_LAST)
                     next_st.phase = S_DONE;
               end
            S_SKIP:
               // Foreign or malformed sub-messages are swallowed by their own length.
               if (in_valid)
               begin
                  next_st.cnt = 16'(st.cnt + 16'h0001);
                  if (st.cnt == 16'(st.body_len - 16'h0001))
                     next_st.phase = S_DONE;
               end
            S_DONE:
            begin
               next_st.err_flags = chk;
               if (chk != '0)
                  next_st.param_error = 1'b1;
               else
               begin
                  next_st.param_valid            = 1'b1;
                  next_st.msdu_index             = st.body[`OFF_INDEX];
                  next_st.frame_type             = st.body[`OFF_FTYPE][1:0];
                  next_st.subtype                = st.body[`OFF_SUBTYPE][3:0];
                  next_st.to_ds                  = st.body[`OFF_TODS][0];
                  next_st.from_ds                = st.body[`OFF_FROMDS][0];
                  next_st.ordering_or_htctl_flag = st.body[`OFF_ORDER][0];
                  next_st.src_addr               = get_addr(st.body, `OFF_SA);
                  next_st.dst_addr               = get_addr(st.body, `OFF_DA);
                  next_st.bssid                  = get_addr(st.body, `OFF_BSSID);
                  next_st.rcv_addr = use_ta ? get_addr(st.body, `OFF_RA) : '0;
                  next_st.tx_addr  = use_ta ? get_addr(st.body, `OFF_TA) : '0;
                  next_st.msdu_len = {st.body[`OFF_LEN], st.body[`OFF_LEN + 1]};
               end
               next_st.phase   = S_HDR;
               next_st.cnt     = '0;
               next_st.hdr_bad = 1'b0;
            end
            default: next_st.phase = S_HDR;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         st <= '0;
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Stalling for the one result cycle keeps the next header from overlapping it.
   assign in_ready               = st.phase != S_DONE;
   assign param_valid            = st.param_valid;
   assign param_error            = st.param_error;
   assign err_flags              = st.err_flags;
   assign msdu_index             = st.msdu_index;
   assign frame_type             = st.frame_type;
   assign subtype                = st.subtype;
   assign to_ds                  = st.to_ds;
   assign from_ds                = st.from_ds;
   assign ordering_or_htctl_flag = st.ordering_or_htctl_flag;
   assign src_addr               = st.src_addr;
   assign dst_addr               = st.dst_addr;
   assign bssid                  = st.bssid;
   assign rcv_addr               = st.rcv_addr;
   assign tx_addr                = st.tx_addr;
   assign msdu_len               = st.msdu_len;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_done;
      st.phase == S_DONE && clk_en;
   endsequence

   sequence s_rejected;
      param_error && !param_valid;
   endsequence

   a_result_excl: assert property (!(param_valid && param_error))
      else $error("valid and error together");
   a_hdr_reject: assert property (s_done ##0 st.hdr_bad |=> s_rejected ##0 err_flags.hdr)
      else $error("bad header not rejected");
   a_ftype_accept: assert property (param_valid && $rose(param_valid) |->
      frame_type == 2'h0 || frame_type == 2'h2)
      else $error("unsupported frame type accepted");
   a_data_subtype: assert property (param_valid && frame_type == 2'h2 |-> subtype == 4'h0)
      else $error("data subtype not zero");
   a_ta_ignored: assert property (param_valid && !(to_ds && from_ds) |->
      tx_addr == '0 && rcv_addr == '0)
      else $error("unused address forwarded");
   a_pwr_reject: assert property (s_done ##0 st.body[`OFF_PWR] != 8'h00 |=>
      s_rejected ##0 (err_flags.pwr || err_flags.hdr))
      else $error("power save accepted");
   a_more_reject: assert property (s_done ##0 !st.hdr_bad ##0 st.body[`OFF_MORE] != 8'h00
      |=> s_rejected ##0 err_flags.more)
      else $error("more data accepted");
   a_prot_reject: assert property (s_done ##0 !st.hdr_bad ##0 st.body[`OFF_PROT] != 8'h00
      |=> s_rejected ##0 err_flags.prot)
      else $error("protected frame accepted");
   a_order_zero: assert property (param_valid |-> !ordering_or_htctl_flag)
      else $error("order flag accepted as one");
   a_sa_group: assert property (param_valid |-> !src_addr[`ADDR_IG_BIT])
      else $error("group source address accepted");
   a_ta_group: assert property (param_valid && to_ds && from_ds |-> !tx_addr[`ADDR_IG_BIT])
      else $error("group transmitter address accepted");
   a_bssid_bits: assert property (param_valid |->
      !bssid[`ADDR_IG_BIT] && bssid[`ADDR_UL_BIT])
      else $error("bad bssid accepted");
   a_len_limit: assert property (param_valid |-> msdu_len <= `MSDU_LEN_MAX)
      else $error("msdu length over limit");
   a_done_once: assert property (s_done |=> st.phase == S_HDR ##0 in_ready)
      else $error("result phase not left");

endmodule

/* File: logic/msdu_tx_param_defs.svh */
/*
   Constants of the transmit-parameters sub-message checker: header values,
   body byte offsets, address bit positions and field limits.
   Assumes that it is included by its bare name where the macros are used.
*/
`ifndef MSDU_TX_PARAM_DEFS_SVH
`define MSDU_TX_PARAM_DEFS_SVH

// ----------------------------------------------------------------------
// Sub-message header
// ----------------------------------------------------------------------
`define SUBMSG_TYPE_MSDU  8'h00
`define SUBMSG_TYPE_PHY   8'h01
`define PSET_ID_MSDU      8'h00
`define MSDU_BODY_LEN     16'h0029
`define HDR_LAST          2'h3

// ----------------------------------------------------------------------
// Body byte offsets, counted from the first byte after the header
// ----------------------------------------------------------------------
`define OFF_INDEX   0
`define OFF_FTYPE   1
`define OFF_SUBTYPE 2
`define OFF_TODS    3
`define OFF_FROMDS  4
`define OFF_PWR     5
`define OFF_MORE    6
`define OFF_PROT    7
`define OFF_ORDER   8
`define OFF_SA      9
`define OFF_DA      15
`define OFF_BSSID   21
`define OFF_RA      27
`define OFF_TA      33
`define OFF_LEN     39
`define BODY_LAST   6'h28

// ----------------------------------------------------------------------
// Field values and limits
// ----------------------------------------------------------------------
`define FTYPE_MGMT    8'h00
`define FTYPE_DATA    8'h02
`define SUBTYPE_MAX   8'h0f
`define SUBTYPE_DATA  8'h00
`define FLAG_MAX      8'h01
`define MSDU_LEN_MAX  16'h0fe1
`define ADDR_IG_BIT   40
`define ADDR_UL_BIT   41

`endif

/* File: logic/msdu_tx_param_pkg.sv */
/*
   Types of the transmit-parameters sub-message checker.
   Assumes the constants header is compiled alongside.
*/
package msdu_tx_param_pkg;

   // ----------------------------------------------------------------------
   // Parser phases and stored state
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      S_HDR  = 2'b00,
      S_BODY = 2'b01,
      S_SKIP = 2'b10,
      S_DONE = 2'b11
   } phase_t;

   typedef logic [40:0][7:0] body_t;

   typedef struct packed {
      logic hdr;
      logic ftype;
      logic subtype;
      logic ds;
      logic pwr;
      logic more;
      logic prot;
      logic order;
      logic sa;
      logic ta;
      logic bssid;
      logic len;
   } err_t;

   typedef struct packed {
      phase_t       phase;
      logic [15:0]  cnt;
      logic [15:0]  body_len;
      logic         hdr_bad;
      body_t        body;
      logic         param_valid;
      logic         param_error;
      err_t         err_flags;
      logic [7:0]   msdu_index;
      logic [1:0]   frame_type;
      logic [3:0]   subtype;
      logic         to_ds;
      logic         from_ds;
      logic         ordering_or_htctl_flag;
      logic [47:0]  src_addr;
      logic [47:0]  dst_addr;
      logic [47:0]  bssid;
      logic [47:0]  rcv_addr;
      logic [47:0]  tx_addr;
      logic [15:0]  msdu_len;
   } parse_state_t;

endpackage
